// [tsm_top.sv]
// measurement sequencer with wishbone registers
//
// Chosen here: register access over Wishbone and the placing of the registers.
`include "tsm_params.svh"
`default_nettype none
module tsm_top #(
    parameter int unsigned TOUT_CYC = `TSM_TOUT_CYC
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // converter
    output logic                       adc_start_o,
    output tsm_pkg::tsm_adc_req_t      adc_req_o,
    input  wire tsm_pkg::tsm_adc_rsp_t adc_rsp_i,
    output logic                       pwr_down_o,
    // serial interface support pins
    input  wire logic                  scl_i,
    output logic                       serial_reset_o,
    input  wire logic [1:0]            address_select_pin_i,
    output logic      [6:0]            bus_addr_o,
    // open-drain alerts
    output logic                       critical_o,
    output logic                       critical_oe_o,
    output logic                       warning_o,
    output logic                       warning_oe_o
);

    // ****************************************
    // bus decode
    // ****************************************
    tsm_pkg::tsm_state_t state;
    logic [15:0]         cfg;
    logic [15:0]         crit_lim;
    logic [15:0]         warn_lim;
    logic [15:0]         next_cfg;
    logic                wb_req;
    logic                wr;
    logic                rd;
    logic                cfg_wr;
    logic                next_active;
    logic                sts_rd;
    logic                lo_lane;

    // the request is taken on the edge that raises ack
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = wb_req & wb_we_i;
    assign rd      = wb_req & ~wb_we_i;
    assign lo_lane = wb_sel_i[0] | wb_sel_i[1];
    assign cfg_wr  = wr & lo_lane & (wb_adr_i == `TSM_OFS_CFG);
    assign sts_rd  = rd & (wb_adr_i == `TSM_OFS_MASKEN);

    // byte lane merge of the config word
    always_comb begin
        next_cfg = cfg;
        if (wb_sel_i[0]) begin
            next_cfg[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            next_cfg[15:8] = wb_dat_i[15:8];
        end
    end

    // both power-down codes have the two kind bits low
    assign next_active = next_cfg[`TSM_MODE_SH] | next_cfg[`TSM_MODE_BUS];

    // one shared setting drives every channel
    logic       shunt_on;
    logic       bus_on;
    logic       cont_on;
    logic [2:0] avg_sh;
    assign shunt_on = cfg[`TSM_MODE_SH];
    assign bus_on   = cfg[`TSM_MODE_BUS];
    assign cont_on  = cfg[`TSM_MODE_CONT];
    assign avg_sh   = cfg[`TSM_AVG_LSB +: 3];

    // ****************************************
    // measurement list
    // ****************************************
    // item 2c is shunt of channel c, 2c+1 its bus
    logic [5:0] item_en;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            item_en[i] = cfg[`TSM_CHEN_LSB + i / 2]
                       & ((i % 2 == 1) ? bus_on : shunt_on);
        end
    end

    // lowest enabled item after the current one
    logic [2:0] cur;
    logic       restart;
    logic       found;
    logic [2:0] pick;
    always_comb begin
        found = 1'b0;
        pick  = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (item_en[i] && (restart || 3'(i) > cur)) begin
                found = 1'b1;
                pick  = 3'(i);
            end
        end
    end

    logic pass_done;
    assign pass_done = (state == tsm_pkg::ST_PICK) & ~cfg_wr & ~found
                     & (~cont_on | (item_en != 6'h00));

    // ****************************************
    // sequencer
    // ****************************************
    logic [`TSM_WAKE_W-1:0] wcnt;
    logic                   conv_done;
    assign conv_done = (state == tsm_pkg::ST_CONV) & adc_rsp_i.done
                     & ~cfg_wr;

    // a config write aborts the pass in flight and starts over
    always_ff @(posedge clk_i) begin
        adc_start_o <= 1'b0;
        if (rst_i) begin
            state     <= tsm_pkg::ST_OFF;
            wcnt      <= '0;
            cur       <= 3'h0;
            restart   <= 1'b1;
            adc_req_o <= '0;
        end else begin
            unique case (state)
                tsm_pkg::ST_OFF: begin
                    if (cfg_wr && next_active) begin
                        state <= tsm_pkg::ST_WAKE;
                        wcnt  <= `TSM_WAKE_W'(`TSM_WAKE_CYC - 1);
                    end
                end
                tsm_pkg::ST_WAKE: begin
                    if (cfg_wr && !next_active) begin
                        state <= tsm_pkg::ST_OFF;
                    end else if (wcnt == '0) begin
                        state   <= tsm_pkg::ST_PICK;
                        restart <= 1'b1;
                    end else begin
                        wcnt <= wcnt - 1'b1;
                    end
                end
                tsm_pkg::ST_PICK: begin
                    if (cfg_wr) begin
                        restart <= 1'b1;
                        if (!next_active) begin
                            state <= tsm_pkg::ST_OFF;
                        end
                    end else if (found) begin
                        // shunt before bus, channel by channel
                        adc_start_o   <= 1'b1;
                        adc_req_o.ch  <= pick[2:1];
                        adc_req_o.bus <= pick[0];
                        // each kind has its own time
                        adc_req_o.ct  <= pick[0]
                            ? cfg[`TSM_BUSCT_LSB +: 3]
                            : cfg[`TSM_SHCT_LSB +: 3];
                        cur     <= pick;
                        restart <= 1'b0;
                        state   <= tsm_pkg::ST_CONV;
                    end else if (!cont_on) begin
                        state <= tsm_pkg::ST_OFF;
                    end else if (item_en != 6'h00) begin
                        restart <= 1'b1;
                    end
                end
                tsm_pkg::ST_CONV: begin
                    if (cfg_wr) begin
                        restart <= 1'b1;
                        state   <= next_active ? tsm_pkg::ST_PICK
                                               : tsm_pkg::ST_OFF;
                    end else if (adc_rsp_i.done) begin
                        state <= tsm_pkg::ST_PICK;
                    end
                end
            endcase
        end
    end

    // power-down flag for the analog front end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_down_o <= 1'b1;
        end else begin
            pwr_down_o <= (state == tsm_pkg::ST_OFF);
        end
    end

    // ****************************************
    // results and averaging
    // ****************************************
    logic signed [15:0] res [0:5];
    logic signed [15:0] sample;
    logic signed [15:0] old;
    logic signed [16:0] diff;
    logic signed [16:0] quot;
    logic signed [15:0] next_avg;

    // both kinds left aligned: bus lsb lands on 8 mV
    assign sample   = {adc_rsp_i.data, `TSM_RES_SHIFT'(0)};
    assign old      = res[cur];
    assign diff     = 17'(sample) - 17'(old);
    assign quot     = diff >>> avg_sh;
    assign next_avg = 16'(old + quot[15:0]);

    // one write per result keeps reads coherent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 6; i++) begin
                res[i] <= '0;
            end
        end else if (conv_done) begin
            res[cur] <= next_avg;
        end
    end

    // alert flags, per sample and per average
    logic crit_flag;
    logic warn_flag;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crit_flag <= 1'b0;
            warn_flag <= 1'b0;
        end else if (conv_done) begin
            crit_flag <= sample > $signed(crit_lim);
            warn_flag <= next_avg > $signed(warn_lim);
        end
    end

    // open drain: pull low while a flag stands
    always_ff @(posedge clk_i) begin
        critical_o    <= 1'b0;
        warning_o     <= 1'b0;
        if (rst_i) begin
            critical_oe_o <= 1'b0;
            warning_oe_o  <= 1'b0;
        end else begin
            critical_oe_o <= crit_flag;
            warning_oe_o  <= warn_flag;
        end
    end

    // ****************************************
    // conversion ready flag
    // ****************************************
    logic conversion_ready_flag;
    // a completing pass wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_ready_flag <= 1'b0;
        end else if (pass_done) begin
            conversion_ready_flag <= 1'b1;
        end else if ((cfg_wr && next_active) || sts_rd) begin
            conversion_ready_flag <= 1'b0;
        end
    end

    // ****************************************
    // register writes and reads
    // ****************************************
    // writes are taken in every state, power-down too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg      <= `TSM_CFG_RST;
            crit_lim <= `TSM_LIM_RST;
            warn_lim <= `TSM_LIM_RST;
        end else if (wr) begin
            if (wb_adr_i == `TSM_OFS_CFG) begin
                cfg <= next_cfg;
            end
            if (wb_adr_i == `TSM_OFS_CRIT && wb_sel_i[0]) begin
                crit_lim[7:0] <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `TSM_OFS_CRIT && wb_sel_i[1]) begin
                crit_lim[15:8] <= wb_dat_i[15:8];
            end
            if (wb_adr_i == `TSM_OFS_WARN && wb_sel_i[0]) begin
                warn_lim[7:0] <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `TSM_OFS_WARN && wb_sel_i[1]) begin
                warn_lim[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // read data and ack; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (rd) begin
                wb_dat_o <= '0;
                if (wb_adr_i == `TSM_OFS_CFG) begin
                    wb_dat_o[15:0] <= cfg;
                end else if (wb_adr_i >= `TSM_OFS_RES0 &&
                             wb_adr_i <= `TSM_OFS_RES5 &&
                             wb_adr_i[1:0] == 2'h0) begin
                    wb_dat_o[15:0] <= res[3'(wb_adr_i[7:2] - 6'h01)];
                end else if (wb_adr_i == `TSM_OFS_CRIT) begin
                    wb_dat_o[15:0] <= crit_lim;
                end else if (wb_adr_i == `TSM_OFS_WARN) begin
                    wb_dat_o[15:0] <= warn_lim;
                end else if (wb_adr_i == `TSM_OFS_MASKEN) begin
                    wb_dat_o[`TSM_ME_CONVERSION_READY_FLAG] <= conversion_ready_flag;
                    wb_dat_o[`TSM_ME_PD]   <= pwr_down_o;
                    wb_dat_o[`TSM_ME_CRIT] <= crit_flag;
                    wb_dat_o[`TSM_ME_WARN] <= warn_flag;
                end else if (wb_adr_i == `TSM_OFS_ADDR) begin
                    wb_dat_o[6:0] <= bus_addr_o;
                end
            end
        end
    end

    // ****************************************
    // serial clock timeout
    // ****************************************
    logic                   scl_s1;
    logic                   scl_s2;
    logic [`TSM_TOUT_W-1:0] tcnt;

    // pin crosses in two flops before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
        end
    end

    // saturating low-time counter, one reset pulse per stall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tcnt           <= '0;
            serial_reset_o <= 1'b0;
        end else begin
            serial_reset_o <= ~scl_s2
                & (tcnt == `TSM_TOUT_W'(TOUT_CYC - 1));
            if (scl_s2) begin
                tcnt <= '0;
            end else if (tcnt != `TSM_TOUT_W'(TOUT_CYC)) begin
                tcnt <= tcnt + 1'b1;
            end
        end
    end

    // ****************************************
    // address select strap
    // ****************************************
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [1:0] strap_cnt;

    // caught once, after the synchroniser has filled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_s1     <= 2'h0;
            sel_s2     <= 2'h0;
            strap_cnt  <= 2'h0;
            bus_addr_o <= `TSM_ADDR_BASE;
        end else begin
            sel_s1 <= address_select_pin_i;
            sel_s2 <= sel_s1;
            if (strap_cnt != 2'h3) begin
                strap_cnt <= strap_cnt + 1'b1;
            end
            if (strap_cnt == 2'h2) begin
                bus_addr_o <= `TSM_ADDR_BASE | {5'h00, sel_s2};
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_KIND_ON: assert property (
        adc_start_o |-> (adc_req_o.bus ? bus_on : shunt_on))
        else $error("conversion of a kind the mode excludes");

    AST_SKIP_OFF: assert property (
        adc_start_o |-> cfg[`TSM_CHEN_LSB + 32'(adc_req_o.ch)])
        else $error("disabled channel was converted");

    AST_AVG_LOAD: assert property (
        conv_done |=> res[$past(cur)] == $past(next_avg))
        else $error("result not loaded with new average");

    AST_WAKE_STEP: assert property (
        state == tsm_pkg::ST_OFF && cfg_wr && next_active
        |=> state == tsm_pkg::ST_WAKE
            && wcnt == `TSM_WAKE_W'(`TSM_WAKE_CYC - 1))
        else $error("recovery wait not started");

    AST_CONVERSION_READY_FLAG_CFG: assert property (
        cfg_wr && next_active && !pass_done |=> !conversion_ready_flag)
        else $error("config write left ready flag set");

    AST_CONVERSION_READY_FLAG_RD: assert property (
        sts_rd && !pass_done |=> !conversion_ready_flag)
        else $error("status read left ready flag set");

    AST_SINGLE_END: assert property (
        pass_done && !cont_on |=> state == tsm_pkg::ST_OFF && conversion_ready_flag)
        else $error("single pass did not power down");

    AST_ACK_PD: assert property (
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus request not answered in one cycle");

    AST_CONT_RUN: assert property (
        pass_done && cont_on && !cfg_wr
        |=> state == tsm_pkg::ST_PICK && restart)
        else $error("continuous mode stopped");

    AST_TOUT: assert property (
        serial_reset_o |-> $past(!scl_s2))
        else $error("timeout pulse with clock high");

endmodule
`default_nettype wire

// [tsm_params.svh]
// constants for the three-channel monitor sequencer
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TSM_OFS_CFG     8'h00
`define TSM_OFS_RES0    8'h04
`define TSM_OFS_RES5    8'h18
`define TSM_OFS_CRIT    8'h1C
`define TSM_OFS_WARN    8'h20
`define TSM_OFS_MASKEN  8'h24
`define TSM_OFS_ADDR    8'h28

// ****************************************
// configuration fields and reset values
// ****************************************
`define TSM_MODE_SH     0
`define TSM_MODE_BUS    1
`define TSM_MODE_CONT   2
`define TSM_SHCT_LSB    3
`define TSM_BUSCT_LSB   6
`define TSM_AVG_LSB     9
`define TSM_CHEN_LSB    12
`define TSM_CFG_RST     16'h7007
`define TSM_LIM_RST     16'h7FF8
`define TSM_RES_SHIFT   3
`define TSM_ADDR_BASE   7'h40

// status bits of the mask and enable register
`define TSM_ME_CONVERSION_READY_FLAG     0
`define TSM_ME_PD       1
`define TSM_ME_CRIT     2
`define TSM_ME_WARN     3

// ****************************************
// timing
// ****************************************
`define TSM_CLK_MHZ     40
`define TSM_WAKE_US     40
`define TSM_WAKE_CYC    (`TSM_WAKE_US * `TSM_CLK_MHZ)
`define TSM_WAKE_W      11
`define TSM_TOUT_MS     28
`define TSM_TOUT_CYC    (`TSM_TOUT_MS * `TSM_CLK_MHZ * 1000)
`define TSM_TOUT_W      21

`endif

// [tsm_pkg.sv]
// types shared by the monitor sequencer
`default_nettype none
package tsm_pkg;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_WAKE = 4'h2,
        ST_PICK = 4'h4,
        ST_CONV = 4'h8
    } tsm_state_t;

    // mode codes of the configuration register
    typedef enum logic [2:0] {
        MD_PD0     = 3'h0,
        MD_SS_SH   = 3'h1,
        MD_SS_BUS  = 3'h2,
        MD_SS_BOTH = 3'h3,
        MD_PD1     = 3'h4,
        MD_CT_SH   = 3'h5,
        MD_CT_BUS  = 3'h6,
        MD_CT_BOTH = 3'h7
    } tsm_mode_t;

    // request to the converter
    typedef struct packed {
        logic [1:0] ch;
        logic       bus;
        logic [2:0] ct;
    } tsm_adc_req_t;

    // answer from the converter
    typedef struct packed {
        logic        done;
        logic [12:0] data;
    } tsm_adc_rsp_t;

endpackage
`default_nettype wire

// [tsm_adc_model.sv]
// behavioural converter on the far side of the sequencer
`default_nettype none
module tsm_adc_model (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // converter link
    input  wire logic                  start_i,
    input  wire tsm_pkg::tsm_adc_req_t req_i,
    output tsm_pkg::tsm_adc_rsp_t      rsp_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt;
    logic       busy;
    logic       slow;

    // prompt and slow answers in turn; a new start aborts the old one
    // data is scrambled between answers so no stale value looks valid
    always_ff @(posedge clk_i) begin
        rsp_o.done <= 1'b0;
        rsp_o.data <= ~rsp_o.data;
        if (rst_i) begin
            busy  <= 1'b0;
            cnt   <= 4'h0;
            slow  <= 1'b0;
            rsp_o <= '0;
        end else if (start_i) begin
            busy <= 1'b1;
            cnt  <= slow ? 4'h6 : 4'h0;
            slow <= ~slow;
        end else if (busy && cnt == 4'h0) begin
            busy       <= 1'b0;
            rsp_o.done <= 1'b1;
            rsp_o.data <= {8'h01, req_i.ch, req_i.bus, 2'b01};
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

// [tsm_top_tb_top.sv]
// self-checking bench for the monitor sequencer
`default_nettype none
module tsm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_i, rst_i, wb_cyc, wb_stb, wb_we, scl;
    logic [7:0]            wb_adr;
    logic [31:0]           wb_dat, wb_dat_o, rd;
    logic                  wb_ack_o, adc_start_o, pwr_down_o, ser_rst;
    logic                  crit_o, crit_oe, warn_o, warn_oe;
    logic [6:0]            bus_addr_o;
    tsm_pkg::tsm_adc_req_t adc_req;
    tsm_pkg::tsm_adc_rsp_t adc_rsp;
    tsm_pkg::tsm_adc_req_t q[$];
    logic [5:0]            seq [4] = '{6'h05, 6'h0A, 6'h25, 6'h2A};
    int                    n_errors, checks_done, n;

    // ****************************************
    // design, converter and monitor
    // ****************************************
    tsm_top #(.TOUT_CYC(50)) u_tsm_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .adc_start_o(adc_start_o), .adc_req_o(adc_req),
        .adc_rsp_i(adc_rsp), .pwr_down_o(pwr_down_o), .scl_i(scl),
        .serial_reset_o(ser_rst), .address_select_pin_i(2'h2),
        .bus_addr_o(bus_addr_o), .critical_o(crit_o),
        .critical_oe_o(crit_oe), .warning_o(warn_o), .warning_oe_o(warn_oe));
    tsm_adc_model u_tsm_adc_model (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(adc_start_o), .req_i(adc_req), .rsp_o(adc_rsp));

    // log every conversion request in order
    always @(posedge clk_i) if (adc_start_o === 1'b1) q.push_back(adc_req);

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] enc(input logic [5:0] r);
        return {16'h0000, 8'h01, r[5:3], 2'b01, 3'b000};
    endfunction

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (k >= 20) n_errors++;
    endtask

    task rchk(input string what, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(what, e, rd);
    endtask

    // first start of a pass, then power-down at its end
    task pass_wait;
        n = 0;
        while (adc_start_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        while (pwr_down_o !== 1'b1 && n < 2500) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2500) n_errors++;
    endtask

    task complete_run;
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog, well past the roughly 17k cycles of the tests
    initial begin
        #1_000_000;
        n_errors++;
        complete_run();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {rst_i, scl} = 2'b11;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("config", 8'h00, 32'h7007);
        rchk("status", 8'h24, 32'h0002);
        rchk("limit", 8'h1C, 32'h7FF8);
        rchk("unmapped", 8'h30, 32'h0);
        rchk("address", 8'h28, 32'h0042);
        chk("addr pins", 32'h42, {25'h0, bus_addr_o});
        // single pass, ch0 and ch2, distinct time codes
        q.delete();
        wb(1'b1, 8'h00, 32'h50AB);
        pass_wait();
        chk("count", 32'h4, 32'(q.size()));
        for (int i = 0; i < 4; i++)
            chk("order", seq[i], 32'(q[i]));
        wb(1'b1, 8'h00, 32'h5000);
        rchk("flag kept", 8'h24, 32'h0003);
        rchk("flag read", 8'h24, 32'h0002);
        for (int i = 0; i < 4; i++)
            rchk("result", 8'h04 + {seq[i][5:3], 2'b00},
                 enc(seq[i]));
        rchk("skipped", 8'h0C, 32'h0);
        // single-shot codes on ch1, each written twice
        for (int m = 1; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                q.delete();
                wb(1'b1, 8'h00, 32'h2000 | m);
                pass_wait();
                chk("pass size", (m == 3) ? 2 : 1, 32'(q.size()));
                chk("kind", 32'(m == 2), 32'(q[0].bus));
                chk("channel", 32'h1, 32'(q[0].ch));
            end
        end
        // continuous shunt on ch0, flag cleared by the write
        q.delete();
        wb(1'b1, 8'h00, 32'h1005);
        wb(1'b0, 8'h24, 32'h0);
        chk("flag cleared", 32'h0, rd & 32'h1);
        n = 3;
        while (adc_start_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk("wake", 32'h1, 32'(n >= 1599 && n <= 1610));
        n = 0;
        while (q.size() < 4 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk("running", 32'h0, 32'(pwr_down_o));
        chk("item", 32'h0, 32'(q[3]));
        wb(1'b1, 8'h00, 32'h1000);
        repeat (3) @(posedge clk_i);
        chk("stopped", 32'h1, 32'(pwr_down_o));
        n = q.size();
        repeat (2000) @(posedge clk_i);
        chk("idle", 32'(n), 32'(q.size()));
        // alerts with zero limits
        wb(1'b1, 8'h1C, 32'h0);
        wb(1'b1, 8'h20, 32'h0);
        wb(1'b1, 8'h00, 32'h1001);
        pass_wait();
        chk("critical oe", 32'h1, 32'(crit_oe));
        chk("critical data", 32'h0, 32'(crit_o));
        chk("warning oe", 32'h1, 32'(warn_oe));
        // serial clock held low past the timeout
        scl <= 1'b0;
        n = 0;
        while (ser_rst !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk("timeout", 32'h1, 32'(n >= 50 && n <= 56));
        complete_run();
    end
endmodule
`default_nettype wire
